// >>> plc_pipe_model.sv
/*
  Pipeline-side model: supplies the lower-level label registers and the
  level-2 alternative-space control. Assumes the bench owns the request port.
*/
`timescale 1ns/1ps
`default_nettype none
module plc_pipe_model #(
  parameter logic [47:0] L0 = 48'h0102_0003_0004,
  parameter logic [47:0] L1 = 48'h1112_0013_0014,
  parameter logic [47:0] L2 = 48'h2122_0023_0024
) (
  input  wire logic           alt_req,
  output plc_pkg::plc_label_s level0_label,
  output plc_pkg::plc_label_s level1_label,
  output plc_pkg::plc_label_s level2_label,
  output logic                level2_alt_space
);
  import plc_pkg::*;
  // ------------------------------------------------------------
  // Distinct per-level labels so a wrong source pick shows up
  // ------------------------------------------------------------
  assign level0_label     = L0;
  assign level1_label     = L1;
  assign level2_label     = L2;
  assign level2_alt_space = alt_req;
endmodule : plc_pipe_model
`default_nettype wire

// >>> plc_pkg.sv
/*
  Constants, field layout and carrier types for the partition label control
  register bank. Assumes a 64-bit system-register move port and a label path
  that consumes one label per cycle.
*/
`default_nettype none
package plc_pkg;

  // ----------------------------------------------------------------------
  // System register encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0]  TOP_OP0     = 2'h3;
  localparam logic [2:0]  TOP_OP1     = 3'h6;
  localparam logic [3:0]  TOP_CRN     = 4'ha;
  localparam logic [3:0]  TOP_CRM     = 4'h5;
  localparam logic [2:0]  TOP_OP2     = 3'h0;
  localparam logic [1:0]  HYP_OP0     = 2'h3;
  localparam logic [2:0]  HYP_OP1     = 3'h4;
  localparam logic [3:0]  HYP_CRN     = 4'ha;
  localparam logic [3:0]  HYP_CRM     = 4'h4;
  localparam logic [2:0]  HYP_OP2     = 3'h0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GLOBAL_LABEL_ENABLE_BIT   = 63;
  localparam int LOWER_LEVEL_TRAP_BIT      = 62;
  localparam int SECURE_DEFAULT_BIT        = 61;
  localparam int FORCE_NONSECURE_BIT       = 60;
  localparam int ALT_SPACE_HIER_ENABLE_BIT = 57;
  localparam int ALT_SPACE_HIER_FORCE_BIT  = 56;
  localparam int TOP_LEVEL_ALT_SPACE_BIT   = 55;
  localparam int ROOT_ALT_SPACE_BIT        = 52;
  localparam int ID_REGISTER_TRAP_BIT      = 31;
  localparam int GUEST_APP_LOCK_BIT        = 8;
  localparam int LEVEL1_MAP_ENABLE_BIT     = 1;
  localparam int LEVEL0_MAP_ENABLE_BIT     = 0;
  localparam logic [63:0] LABEL_FIELD_MASK = 64'h0000_ffff_ffff_ffff;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [63:0] TOP_RESET       = 64'h4000_0000_0000_0000;
  localparam logic [63:0] HYP_RESET_NOEL3 = 64'h0000_0000_8000_0000;
  localparam logic [63:0] HYP_RESET_EL3   = 64'h0000_0000_0000_0000;
  localparam logic [15:0] DEFAULT_PARTID  = 16'h0000;
  localparam logic [7:0]  DEFAULT_PMG     = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SEC_SECURE, SEC_NONSECURE, SEC_ROOT, SEC_REALM} plc_sec_e;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } plc_enc_s;

  typedef struct packed {
    logic [7:0]  data_monitor_group;
    logic [7:0]  instr_monitor_group;
    logic [15:0] data_partition_id;
    logic [15:0] instr_partition_id;
  } plc_label_s;

  typedef struct packed {
    plc_label_s label;
    logic       alt_space;
    logic       nonsecure;
    logic       map_enable;
  } plc_out_s;

  typedef struct packed {
    logic        undefined;
    logic        trap_el3;
    logic        trap_el2;
    logic [63:0] rdata;
  } plc_resp_s;

endpackage : plc_pkg
`default_nettype wire

// >>> plc_regs.sv
/*
  Partition label control register bank: the top-level label register and
  the hypervisor partition control register, plus the label selection that
  they steer. Assumes the pipeline presents one system-register move per
  request pulse and supplies the lower-level label registers and the
  current level, security state and hypervisor controls on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module plc_regs #(
  parameter bit HAS_EL3              = 1'b1,
  parameter bit VIRT_CAPABILITY      = 1'b1,
  parameter bit SECURE_DEFAULT_OVERRIDE_CAPABILITY    = 1'b1,
  parameter bit FORCE_NONSECURE_LABEL_CAPABILITY  = 1'b1,
  parameter bit FORCE_NONSECURE_LABEL_READS_ONE   = 1'b0,
  parameter bit ALT_SPACE_CAPABILITY = 1'b1
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire plc_pkg::plc_enc_s   req_enc,
  input  wire logic [63:0]         req_wdata,
  input  wire logic [1:0]          cur_el,
  input  wire plc_pkg::plc_sec_e   cur_sec,
  input  wire logic                el2_enabled,
  input  wire logic                hcr_nv,
  input  wire logic                hcr_e2h,
  input  wire logic                trap_general_exceptions,
  input  wire logic                fetch_not_data,
  input  wire plc_pkg::plc_label_s level0_label,
  input  wire plc_pkg::plc_label_s level1_label,
  input  wire plc_pkg::plc_label_s level2_label,
  input  wire logic                level2_alt_space,
  output logic                     resp_valid,
  output plc_pkg::plc_resp_s       resp,
  output logic                     lower_level_trap,
  output logic                     id_register_trap,
  output plc_pkg::plc_out_s        label_out
);
  import plc_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [63:0] top_r;
  logic [63:0] top_nxt;
  logic [63:0] hyp_r;
  logic [63:0] hyp_nxt;
  logic        resp_valid_r;
  plc_resp_s   resp_r;
  plc_resp_s   resp_nxt;
  plc_out_s    label_r;
  plc_out_s    label_nxt;

  // ----------------------------------------------------------------------
  // Writable masks and read-back forcing
  // ----------------------------------------------------------------------
  // Reserved and absent-capability bits never store, so they read zero
  logic [63:0] top_wmask;
  logic [63:0] top_force_one;
  logic [63:0] hyp_wmask;
  logic [63:0] hyp_reset_val;

  always_comb begin
    top_wmask = LABEL_FIELD_MASK;
    top_wmask[GLOBAL_LABEL_ENABLE_BIT]   = 1'b1;
    top_wmask[LOWER_LEVEL_TRAP_BIT]      = 1'b1;
    top_wmask[SECURE_DEFAULT_BIT]        = SECURE_DEFAULT_OVERRIDE_CAPABILITY;
    top_wmask[FORCE_NONSECURE_BIT]       = FORCE_NONSECURE_LABEL_CAPABILITY & ~FORCE_NONSECURE_LABEL_READS_ONE;
    top_wmask[ALT_SPACE_HIER_ENABLE_BIT] = ALT_SPACE_CAPABILITY;
    top_wmask[ALT_SPACE_HIER_FORCE_BIT]  = ALT_SPACE_CAPABILITY;
    top_wmask[TOP_LEVEL_ALT_SPACE_BIT]   = ALT_SPACE_CAPABILITY;
    top_wmask[ROOT_ALT_SPACE_BIT]        = ALT_SPACE_CAPABILITY;
  end

  always_comb begin
    top_force_one = 64'h0000_0000_0000_0000;
    top_force_one[FORCE_NONSECURE_BIT] = FORCE_NONSECURE_LABEL_CAPABILITY & FORCE_NONSECURE_LABEL_READS_ONE;
  end

  always_comb begin
    hyp_wmask = 64'h0000_0000_0000_0000;
    hyp_wmask[ID_REGISTER_TRAP_BIT]  = VIRT_CAPABILITY;
    hyp_wmask[GUEST_APP_LOCK_BIT]    = VIRT_CAPABILITY;
    hyp_wmask[LEVEL1_MAP_ENABLE_BIT] = VIRT_CAPABILITY;
    hyp_wmask[LEVEL0_MAP_ENABLE_BIT] = VIRT_CAPABILITY;
  end

  // Without level 3 the ID trap comes up set; otherwise zero for determinism
  assign hyp_reset_val = (HAS_EL3 ? HYP_RESET_EL3 : HYP_RESET_NOEL3) & hyp_wmask;

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------
  // Top register fields, with the read-one override already applied
  logic [63:0] top_view;
  logic        global_label_enable;
  logic        trap_lower_bit;
  logic        secure_default;
  logic        force_nonsecure;
  logic        alt_space_hier_en;
  logic        alt_space_hier_frc;
  logic        top_level_alt_space;
  logic        root_alt_space_sel;

  assign top_view            = top_r | top_force_one;
  assign global_label_enable = top_view[GLOBAL_LABEL_ENABLE_BIT];
  assign trap_lower_bit      = top_view[LOWER_LEVEL_TRAP_BIT];
  assign secure_default      = top_view[SECURE_DEFAULT_BIT];
  assign force_nonsecure     = top_view[FORCE_NONSECURE_BIT];
  assign alt_space_hier_en   = top_view[ALT_SPACE_HIER_ENABLE_BIT];
  assign alt_space_hier_frc  = top_view[ALT_SPACE_HIER_FORCE_BIT];
  assign top_level_alt_space = top_view[TOP_LEVEL_ALT_SPACE_BIT];
  assign root_alt_space_sel  = top_view[ROOT_ALT_SPACE_BIT];

  // Hypervisor register fields
  logic        id_trap_bit;
  logic        guest_app_lock;
  logic        level1_map_enable;
  logic        level0_map_enable;

  assign id_trap_bit         = hyp_r[ID_REGISTER_TRAP_BIT];
  assign guest_app_lock      = hyp_r[GUEST_APP_LOCK_BIT];
  assign level1_map_enable   = hyp_r[LEVEL1_MAP_ENABLE_BIT];
  assign level0_map_enable   = hyp_r[LEVEL0_MAP_ENABLE_BIT];

  plc_label_s top_label;
  assign top_label = plc_label_s'(top_view[47:0]);

  // Hypervisor controls only count where level 2 is live in this state
  wire hyp_active = VIRT_CAPABILITY & el2_enabled;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  wire hit_top = (req_enc.op0 == TOP_OP0) && (req_enc.op1 == TOP_OP1) &&
                 (req_enc.crn == TOP_CRN) && (req_enc.crm == TOP_CRM) &&
                 (req_enc.op2 == TOP_OP2);
  wire hit_hyp = (req_enc.op0 == HYP_OP0) && (req_enc.op1 == HYP_OP1) &&
                 (req_enc.crn == HYP_CRN) && (req_enc.crm == HYP_CRM) &&
                 (req_enc.op2 == HYP_OP2);
  wire at_el3  = (cur_el == 2'h3);
  wire at_el2  = (cur_el == 2'h2);
  wire at_el1  = (cur_el == 2'h1);
  wire at_el0  = (cur_el == 2'h0);

  // Lower-level trap only bites when a level 3 exists to take it
  wire el3_trap_live = HAS_EL3 & trap_lower_bit;

  // Top register: level 3 only
  wire top_undef = hit_top & ~at_el3;
  wire top_ok    = hit_top & at_el3;

  // ----------------------------------------------------------------------
  // Hypervisor register access
  // ----------------------------------------------------------------------
  // Level 1 reaches it only via nested trapping; never a direct grant
  wire hyp_undef = hit_hyp & (~VIRT_CAPABILITY | at_el0 |
                              (at_el1 & ~(el2_enabled & hcr_nv)));
  wire hyp_el1_nested = hit_hyp & VIRT_CAPABILITY & at_el1 & el2_enabled & hcr_nv;
  wire hyp_el2_trap3  = hit_hyp & VIRT_CAPABILITY & at_el2 & el3_trap_live;
  wire hyp_trap_el3   = hyp_el2_trap3 | (hyp_el1_nested & el3_trap_live);
  wire hyp_trap_el2   = hyp_el1_nested & ~el3_trap_live;
  wire hyp_ok         = hit_hyp & VIRT_CAPABILITY & (at_el3 | (at_el2 & ~hyp_el2_trap3));

  wire claimed = req_valid & (hit_top | hit_hyp);
  wire top_wr  = req_valid & req_write & top_ok;
  wire hyp_wr  = req_valid & req_write & hyp_ok;

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  // Only a granted write lands; refused and trapped writes leave state alone
  assign top_nxt = top_wr ? (req_wdata & top_wmask) : top_r;
  assign hyp_nxt = hyp_wr ? (req_wdata & hyp_wmask) : hyp_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      top_r <= TOP_RESET;
      hyp_r <= hyp_reset_val;
    end else begin
      top_r <= top_nxt;
      hyp_r <= hyp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Access response
  // ----------------------------------------------------------------------
  // Read data only for a granted read; refused accesses return zero
  wire top_rd = ~req_write & top_ok;
  wire hyp_rd = ~req_write & hyp_ok;

  always_comb begin
    resp_nxt           = '0;
    resp_nxt.undefined = top_undef | hyp_undef;
    resp_nxt.trap_el3  = hyp_trap_el3;
    resp_nxt.trap_el2  = hyp_trap_el2;
    if (top_rd) begin
      resp_nxt.rdata = top_view;
    end else if (hyp_rd) begin
      resp_nxt.rdata = hyp_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resp_valid_r <= 1'b0;
      resp_r       <= '0;
    end else begin
      resp_valid_r <= claimed;
      resp_r       <= claimed ? resp_nxt : resp_r;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp       = resp_r;

  // ----------------------------------------------------------------------
  // Trap controls toward the lower-level register decoders
  // ----------------------------------------------------------------------
  wire id_trap_live = hyp_active & at_el1;

  assign lower_level_trap = el3_trap_live & ~at_el3;
  assign id_register_trap = id_trap_live & id_trap_bit;

  // ----------------------------------------------------------------------
  // Label source selection
  // ----------------------------------------------------------------------
  // Guest applications borrow the kernel's labels under the lock
  wire el0_uses_level1 = hyp_active & guest_app_lock & ~trap_general_exceptions;
  wire src_is_level1   = at_el1 | (at_el0 & el0_uses_level1);
  wire src_is_level0   = at_el0 & ~el0_uses_level1;

  plc_label_s sel_label;
  always_comb begin
    case (cur_el)
      2'h3:    sel_label = top_label;
      2'h2:    sel_label = level2_label;
      2'h1:    sel_label = level1_label;
      2'h0:    sel_label = el0_uses_level1 ? level1_label : level0_label;
      default: sel_label = level0_label;
    endcase
  end

  // ----------------------------------------------------------------------
  // Default label override
  // ----------------------------------------------------------------------
  // Zero labels when globally disabled or under the Secure default
  wire secure_state  = (cur_sec == SEC_SECURE);
  wire force_default = ~global_label_enable |
                       (SECURE_DEFAULT_OVERRIDE_CAPABILITY & secure_state & secure_default);

  plc_label_s default_label;
  assign default_label = '{data_monitor_group: DEFAULT_PMG, instr_monitor_group: DEFAULT_PMG,
                           data_partition_id: DEFAULT_PARTID, instr_partition_id: DEFAULT_PARTID};

  // ----------------------------------------------------------------------
  // Partition space and nonsecure label
  // ----------------------------------------------------------------------
  logic alt_space;
  always_comb begin
    if (!ALT_SPACE_CAPABILITY) begin
      alt_space = 1'b0;
    end else if (at_el3) begin
      alt_space = top_level_alt_space;
    end else if (alt_space_hier_en) begin
      alt_space = level2_alt_space;
    end else begin
      alt_space = alt_space_hier_frc;
    end
  end

  logic nonsecure;
  always_comb begin
    case (cur_sec)
      SEC_NONSECURE: nonsecure = 1'b1;
      SEC_SECURE:    nonsecure = FORCE_NONSECURE_LABEL_CAPABILITY & force_nonsecure;
      SEC_ROOT:      nonsecure = alt_space & root_alt_space_sel;
      SEC_REALM:     nonsecure = 1'b0;
      default:       nonsecure = 1'b0;
    endcase
  end

  // Mapping only applies to the level-0 and level-1 label sources
  wire level0_mapped = src_is_level0 & level0_map_enable &
                       ~(hcr_e2h & trap_general_exceptions);
  wire level1_mapped = src_is_level1 & level1_map_enable;
  wire map_enable    = hyp_active & ~force_default &
                       (level0_mapped | level1_mapped);

  // ----------------------------------------------------------------------
  // Label output
  // ----------------------------------------------------------------------
  // Space still follows the normal choice when the default label is used
  plc_label_s chosen_label;
  assign chosen_label = force_default ? default_label : sel_label;

  always_comb begin
    label_nxt            = '0;
    label_nxt.label      = chosen_label;
    label_nxt.alt_space  = alt_space;
    label_nxt.nonsecure  = nonsecure;
    label_nxt.map_enable = map_enable;
  end

  // Recomputed every cycle from live state; nothing is held across a write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      label_r <= '0;
    end else begin
      label_r <= label_nxt;
    end
  end

  assign label_out = label_r;

  // Fetch versus data picks fields downstream; kept as a hint only
  wire unused_fetch = fetch_not_data;

endmodule : plc_regs
`default_nettype wire

// >>> plc_regs_checker.sv
/*
  Port-level assertions for the partition label register bank.
  Assumes one clock, synchronous active-high reset, bound into plc_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module plc_regs_checker (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              req_valid,
  input wire plc_pkg::plc_enc_s req_enc,
  input wire logic [1:0]        cur_el,
  input wire plc_pkg::plc_sec_e cur_sec,
  input wire logic              el2_enabled,
  input wire logic              resp_valid,
  input wire plc_pkg::plc_resp_s resp,
  input wire logic              lower_level_trap,
  input wire logic              id_register_trap,
  input wire plc_pkg::plc_out_s label_out
);
  import plc_pkg::*;
  // ------------------------------------------------------------
  // Decode and checks
  // ------------------------------------------------------------
  wire logic is_top = req_enc == {TOP_OP0, TOP_OP1, TOP_CRN, TOP_CRM, TOP_OP2};
  wire logic is_hyp = req_enc == {HYP_OP0, HYP_OP1, HYP_CRN, HYP_CRM, HYP_OP2};
  wire logic claim  = req_valid && (is_top || is_hyp);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_RESP_NEXT: assert property (claim |=> resp_valid)
    else $error("no response after claimed request");
  AST_RESP_NONE: assert property (!claim |=> !resp_valid)
    else $error("response without claimed request");
  AST_RESP_HOLD: assert property (!claim |=> $stable(resp))
    else $error("response changed without request");
  AST_TOP_LOW_UNDEF: assert property (req_valid && is_top && cur_el != 2'h3 |=> resp.undefined && resp.rdata == 64'h0)
    else $error("top register reached below level 3");
  AST_TOP_EL3_OK: assert property (req_valid && is_top && cur_el == 2'h3 |=> !(resp.undefined || resp.trap_el3 || resp.trap_el2))
    else $error("top register refused at level 3");
  AST_HYP_EL0_UNDEF: assert property (req_valid && is_hyp && cur_el == 2'h0 |=> resp.undefined)
    else $error("hypervisor register reached at level 0");
  AST_TRAP_RESET: assert property ($fell(reset) && cur_el != 2'h3 |-> lower_level_trap)
    else $error("lower trap not set after reset");
  AST_TRAP_EL3: assert property (cur_el == 2'h3 |-> !lower_level_trap)
    else $error("lower trap raised at level 3");
  AST_LABEL_RESET: assert property ($fell(reset) |=> label_out.label == 48'h0)
    else $error("label not default after reset");
  AST_ID_TRAP: assert property (id_register_trap |-> cur_el == 2'h1 && el2_enabled)
    else $error("id trap outside level 1");
  AST_MAP_EL3: assert property (cur_el == 2'h3 |=> !label_out.map_enable)
    else $error("mapping at level 3");
  AST_REALM_NS: assert property (cur_sec == SEC_REALM |=> !label_out.nonsecure)
    else $error("nonsecure label in realm state");
  COV_TOP_EL3: cover property (claim && is_top && cur_el == 2'h3);
  COV_ID_TRAP: cover property (id_register_trap);
  COV_MAP: cover property (label_out.map_enable);
endmodule : plc_regs_checker
`default_nettype wire

bind plc_regs plc_regs_checker u_plc_regs_checker (
  .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_enc(req_enc), .cur_el(cur_el),
  .cur_sec(cur_sec), .el2_enabled(el2_enabled), .resp_valid(resp_valid), .resp(resp),
  .lower_level_trap(lower_level_trap), .id_register_trap(id_register_trap), .label_out(label_out));

// >>> plc_regs_tb.sv
/*
  Self-checking bench for the partition label register bank.
  Assumes the pipeline model supplies lower-level labels; bench drives at negedge.
*/
`timescale 1ns/1ps
`default_nettype none
module plc_regs_tb;
  import plc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, tasks and scenarios
  // ------------------------------------------------------------
  localparam logic [15:0] TE = {TOP_OP0, TOP_OP1, TOP_CRN, TOP_CRM, TOP_OP2};
  localparam logic [15:0] HE = {HYP_OP0, HYP_OP1, HYP_CRN, HYP_CRM, HYP_OP2};
  localparam logic [47:0] L0 = 48'h0102_0003_0004;
  localparam logic [47:0] L1 = 48'h1112_0013_0014;
  localparam logic [47:0] LT = 48'h5a6b_1234_5678;
  logic        sys_clk, reset, req_valid, req_write, el2_enabled, hcr_nv, hcr_e2h, tge, alt_req;
  logic [15:0] req_enc;
  logic [63:0] req_wdata;
  logic [1:0]  cur_el;
  plc_sec_e    cur_sec;
  plc_label_s  l0, l1, l2;
  logic        l2_alt, resp_valid, lower_level_trap, id_register_trap;
  plc_resp_s   resp;
  plc_out_s    label_out;
  int          error_cnt, checks_done;
  plc_regs u_plc_regs (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
    .req_enc(req_enc), .req_wdata(req_wdata), .cur_el(cur_el), .cur_sec(cur_sec), .el2_enabled(el2_enabled),
    .hcr_nv(hcr_nv), .hcr_e2h(hcr_e2h), .trap_general_exceptions(tge), .fetch_not_data(1'b0),
    .level0_label(l0), .level1_label(l1), .level2_label(l2), .level2_alt_space(l2_alt),
    .resp_valid(resp_valid), .resp(resp), .lower_level_trap(lower_level_trap),
    .id_register_trap(id_register_trap), .label_out(label_out));
  plc_pipe_model #(.L0(L0), .L1(L1)) u_plc_pipe_model (.alt_req(alt_req), .level0_label(l0),
    .level1_label(l1), .level2_label(l2), .level2_alt_space(l2_alt));
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle request pulse; answer is due at the following edge
  task automatic acc(input logic wr, input logic [15:0] enc, input logic [1:0] el, input logic [63:0] wd,
                     input logic ev, output plc_resp_s r);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_enc   = enc;
    cur_el    = el;
    req_wdata = wd;
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk("resp_valid", 64'(ev), 64'(resp_valid));
    r = resp;
  endtask : acc
  task automatic lab(input logic [1:0] el, input plc_sec_e sec, input logic [50:0] exp);
    @(negedge sys_clk);
    cur_el  = el;
    cur_sec = sec;
    @(negedge sys_clk);
    chk("label_out", 64'(exp), 64'(label_out));
  endtask : lab
  task automatic s_reset;
    plc_resp_s r;
    chk("lower_level_trap", 64'h1, 64'(lower_level_trap));
    acc(1'b0, TE, 2'h3, 64'h0, 1'b1, r);
    chk("top reset", TOP_RESET, r.rdata);
    acc(1'b0, HE, 2'h3, 64'h0, 1'b1, r);
    chk("hyp reset", HYP_RESET_EL3, r.rdata);
    lab(2'h3, SEC_NONSECURE, {48'h0, 3'b010});
  endtask : s_reset
  task automatic s_top;
    plc_resp_s r;
    acc(1'b1, TE, 2'h3, '1, 1'b1, r);
    acc(1'b0, TE, 2'h3, 64'h0, 1'b1, r);
    chk("top mask", 64'hf390_ffff_ffff_ffff, r.rdata);
    acc(1'b1, TE, 2'h1, 64'h0, 1'b1, r);
    chk("top low", 64'h1, 64'(r.undefined));
    acc(1'b1, TE ^ 16'h0001, 2'h3, 64'h0, 1'b0, r);
    acc(1'b0, TE, 2'h3, 64'h0, 1'b1, r);
    chk("top kept", 64'hf390_ffff_ffff_ffff, r.rdata);
  endtask : s_top
  task automatic s_label;
    plc_resp_s r;
    acc(1'b1, TE, 2'h3, {16'h8080, LT}, 1'b1, r);
    lab(2'h3, SEC_NONSECURE, {LT, 3'b110});
    lab(2'h3, SEC_SECURE, {LT, 3'b100});
    acc(1'b1, TE, 2'h3, {16'hb080, LT}, 1'b1, r);
    lab(2'h3, SEC_SECURE, {48'h0, 3'b110});
    lab(2'h3, SEC_ROOT, {LT, 3'b100});
    acc(1'b1, TE, 2'h3, {16'h8090, LT}, 1'b1, r);
    lab(2'h3, SEC_ROOT, {LT, 3'b110});
    acc(1'b1, TE, 2'h3, 64'h8100_0000_0000_0000, 1'b1, r);
    lab(2'h1, SEC_NONSECURE, {L1, 3'b110});
    acc(1'b1, TE, 2'h3, 64'h8200_0000_0000_0000, 1'b1, r);
    alt_req = 1'b1;
    lab(2'h1, SEC_NONSECURE, {L1, 3'b110});
    alt_req = 1'b0;
    lab(2'h1, SEC_NONSECURE, {L1, 3'b010});
    acc(1'b1, TE, 2'h3, 64'h0, 1'b1, r);
    lab(2'h1, SEC_NONSECURE, {48'h0, 3'b010});
    lab(2'h3, SEC_REALM, {48'h0, 3'b000});
  endtask : s_label
  task automatic s_hyp;
    plc_resp_s r;
    el2_enabled = 1'b1;
    acc(1'b1, TE, 2'h3, 64'h8000_0000_0000_0000, 1'b1, r);
    acc(1'b1, HE, 2'h3, '1, 1'b1, r);
    acc(1'b0, HE, 2'h3, 64'h0, 1'b1, r);
    chk("hyp mask", 64'h8000_0103, r.rdata);
    lab(2'h1, SEC_NONSECURE, {L1, 3'b011});
    chk("id_register_trap", 64'h1, 64'(id_register_trap));
    lab(2'h0, SEC_NONSECURE, {L1, 3'b011});
    tge = 1'b1;
    lab(2'h0, SEC_NONSECURE, {L0, 3'b011});
    hcr_e2h = 1'b1;
    lab(2'h0, SEC_NONSECURE, {L0, 3'b010});
    acc(1'b0, HE, 2'h0, 64'h0, 1'b1, r);
    chk("hyp el0", 64'h1, 64'(r.undefined));
    el2_enabled = 1'b0;
    tge = 1'b0;
    lab(2'h0, SEC_NONSECURE, {L0, 3'b010});
  endtask : s_hyp
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog: the sequence is short, so a hang is a fault
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    {reset, req_valid, req_write, el2_enabled, hcr_nv, hcr_e2h, tge, alt_req} = 8'h80;
    req_enc = 16'h0;
    req_wdata = 64'h0;
    cur_el = 2'h2;
    cur_sec = SEC_NONSECURE;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    s_reset();
    s_top();
    s_label();
    s_hyp();
    conclude();
  end
endmodule : plc_regs_tb
`default_nettype wire
